/* twxse_pkg.sv */
// Shared constants and types for the table write, xor and skip execution block
package twxse_pkg;
    // ==========================================================
    // Widths
    localparam int TPTR_W  = 21;
    localparam int PTR_W   = 12;
    localparam int HOLD_N  = 8;
    localparam int HOLD_AW = 3;
    localparam int PTR_N   = 3;

    // ==========================================================
    // Instruction phases
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;

    // ==========================================================
    // Opcodes
    localparam logic [13:0] OPC_TBL_WRITE = 14'h0003;
    localparam logic [6:0]  OPC_TEST_SKIP = 7'h33;
    localparam logic [7:0]  OPC_XOR_LIT   = 8'h0A;
    localparam logic [5:0]  OPC_XOR_FILE  = 6'h06;
    localparam logic [7:0]  OPC_ADD_PTR   = 8'hE8;
    localparam logic [7:0]  OPC_SUB_PTR   = 8'hE9;
    localparam logic [7:0]  OPC_PUSH_LIT  = 8'hEA;
    localparam logic [7:0]  OPC_MOVE_IDX  = 8'hEB;
    localparam logic [15:0] OPC_CALL_W    = 16'h0014;
    localparam logic [15:0] OPC_NOP       = 16'h0000;

    // Table write mode field
    localparam logic [1:0] TW_KEEP     = 2'h0;
    localparam logic [1:0] TW_POST_INC = 2'h1;
    localparam logic [1:0] TW_POST_DEC = 2'h2;
    localparam logic [1:0] TW_PRE_INC  = 2'h3;

    // Addressing
    localparam logic [1:0] PTR_SEL_STACK    = 2'h3;
    localparam logic [1:0] PTR_STACK_IDX    = 2'h2;
    localparam logic [7:0] LIT_OFFSET_MAX   = 8'h5F;
    localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_BANK   = 8'h04;
    localparam logic [7:0] OFS_WORKING_REGISTER   = 8'h08;
    localparam logic [7:0] OFS_STAT   = 8'h0C;
    localparam logic [7:0] OFS_TPTR   = 8'h10;
    localparam logic [7:0] OFS_TLAT   = 8'h14;
    localparam logic [7:0] OFS_PTR0   = 8'h18;
    localparam logic [7:0] PTR_STRIDE = 8'h04;

    // Field positions
    localparam int CTRL_EXT_BIT = 0;
    localparam int STAT_Z_BIT   = 0;
    localparam int STAT_N_BIT   = 1;

    // Reset values
    localparam logic [7:0]  RST_W     = 8'h00;
    localparam logic [3:0]  RST_BANK  = 4'h0;
    localparam logic [20:0] RST_TPTR  = 21'h000000;
    localparam logic [7:0]  RST_LATCH = 8'h00;
    localparam logic [11:0] RST_PTR   = 12'h000;
    localparam logic        RST_EXT   = 1'b0;

    // ==========================================================
    // Execution states
    typedef enum logic [1:0] {
        ST_EXEC,
        ST_TBL2,
        ST_NOP2,
        ST_NOP1
    } twxse_state_type;
endpackage

/* twxse_hold_mem.sv */
// Program memory write holding registers with registered read port
`timescale 1ns/10ps
module twxse_hold_mem
    import twxse_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_b,
    // Write side
    input  wire logic               wr_en,
    input  wire logic [HOLD_AW-1:0] wr_idx,
    input  wire logic [7:0]         wr_data,
    // Read side
    input  wire logic [HOLD_AW-1:0] rd_idx,
    output logic      [7:0]         rd_data
);
    logic [7:0] mem [HOLD_N];

    // ==========================================================
    // Storage
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= RST_LATCH;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule

/* twxse_exec.sv */
// Execution of table write, test-and-skip, xor and pointer adjust instructions
`timescale 1ns/10ps
// What this block does
// - Table write mode: keep, post-inc, post-dec, pre-inc
// - Table latch goes to holding register pointer[2:0]
// - Table pointer is 21 bits, byte addressed
// - Pointer bit 0 picks low or high byte
// - Table write leaves status flags alone
// - Zero test discards fetched instruction, runs nop
// - Test-and-skip: one cycle, two when skipping
// - Skipping two-word instruction costs two nops
// - Access bit 0 access bank, 1 bank select
// - Extended, access bit 0, f<=5Fh: indexed offset
// - Xor literal into working register
// - Xor file, destination bit picks target
// - Both xors update only negative and zero
// - Extended features off unless enable bit set
// - Seven extended literal pointer instructions
// - Stack pointer add/sub variants return afterwards
module twxse_exec
    import twxse_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Instruction stream
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_two_word,
    output logic             instr_take,
    // Data memory
    input  wire logic [7:0]  file_rdata,
    output logic      [11:0] file_addr,
    output logic             file_rd,
    output logic             file_wr,
    output logic      [7:0]  file_wdata,
    // Holding registers
    input  wire logic [2:0]  hold_rd_idx,
    output logic      [7:0]  hold_rd_data,
    // Core sequencing
    output logic      [1:0]  phase,
    output logic             cycle_nop,
    output logic             ret_pop,
    output logic             ext_pass,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata
);
    // ==========================================================
    // Functions
    function automatic logic [11:0] file_address(input logic       acc_b,
                                                 input logic [7:0] f,
                                                 input logic [3:0] bank,
                                                 input logic [11:0] base,
                                                 input logic       ext);
        logic [11:0] a;
        a = {bank, f};
        if (!acc_b) begin
            if (ext && f <= LIT_OFFSET_MAX) begin
                a = 12'(base + {4'h0, f});
            end else if (f <= LIT_OFFSET_MAX) begin
                a = {ACCESS_LOW_BANK, f};
            end else begin
                a = {ACCESS_HIGH_BANK, f};
            end
        end
        return a;
    endfunction

    function automatic logic [TPTR_W-1:0] tptr_step(input logic [TPTR_W-1:0] p,
                                                    input logic dn);
        return dn ? TPTR_W'(p - 21'h1) : TPTR_W'(p + 21'h1);
    endfunction

    // ==========================================================
    // State
    twxse_state_type   state_reg;
    twxse_state_type   state_next;
    logic [1:0]        q_reg;
    logic [15:0]       ir_reg;
    logic              ext_en_reg;
    logic [3:0]        bsr_reg;
    logic [7:0]        w_reg;
    logic              n_reg;
    logic              z_reg;
    logic [TPTR_W-1:0] tptr_reg;
    logic [7:0]        tlat_reg;
    logic [7:0]        hold_latch_reg;
    logic [PTR_W-1:0]  ptr_reg [PTR_N];
    logic              skip_reg;
    logic [31:0]       rd_mux;

    // ==========================================================
    // Decode
    wire ex       = state_reg == ST_EXEC;
    wire at_q1    = q_reg == Q1;
    wire at_q2    = q_reg == Q2;
    wire at_q3    = q_reg == Q3;
    wire at_q4    = q_reg == Q4;
    wire is_tbl   = ir_reg[15:2] == OPC_TBL_WRITE;
    wire [1:0] tw_mode = ir_reg[1:0];
    wire is_tst   = ir_reg[15:9] == OPC_TEST_SKIP;
    wire is_xlw   = ir_reg[15:8] == OPC_XOR_LIT;
    wire is_xwf   = ir_reg[15:10] == OPC_XOR_FILE;
    wire dest_f   = ir_reg[9];
    wire uses_f   = is_tst | is_xwf;
    // Extended opcodes decode to nothing until enabled
    wire is_adj   = ext_en_reg && (ir_reg[15:8] == OPC_ADD_PTR || ir_reg[15:8] == OPC_SUB_PTR);
    wire is_ulnk  = is_adj && ir_reg[7:6] == PTR_SEL_STACK;
    // The other three extended operations are executed elsewhere; only flagged here
    wire is_xoth  = ext_en_reg && (ir_reg == OPC_CALL_W || ir_reg[15:8] == OPC_PUSH_LIT
                                   || ir_reg[15:8] == OPC_MOVE_IDX);
    wire [1:0] ptr_idx = is_ulnk ? PTR_STACK_IDX : ir_reg[7:6];
    wire [11:0] ptr_k  = {6'h00, ir_reg[5:0]};
    wire [11:0] ptr_new = ir_reg[8] ? 12'(ptr_reg[ptr_idx] - ptr_k)
                                    : 12'(ptr_reg[ptr_idx] + ptr_k);
    wire [11:0] f_addr = file_address(ir_reg[8], ir_reg[7:0], bsr_reg, ptr_reg[PTR_STACK_IDX],
                                      ext_en_reg);
    wire [7:0] x_res  = w_reg ^ (is_xlw ? ir_reg[7:0] : file_rdata);
    wire w_we_x   = ex && at_q3 && (is_xlw || (is_xwf && !dest_f));
    wire flg_we   = ex && at_q3 && (is_xlw || is_xwf);
    wire hold_we  = state_reg == ST_TBL2 && at_q4;
    wire pre_inc  = ex && at_q4 && is_tbl && tw_mode == TW_PRE_INC;
    wire post_mv  = hold_we && (tw_mode == TW_POST_INC || tw_mode == TW_POST_DEC);
    wire ptr_we   = ex && at_q4 && is_adj;
    wire load_ir  = at_q4 && state_next == ST_EXEC;

    // Register port decode
    wire wr_ctrl  = reg_wr && reg_addr == OFS_CTRL;
    wire wr_bank  = reg_wr && reg_addr == OFS_BANK;
    wire wr_w     = reg_wr && reg_addr == OFS_WORKING_REGISTER;
    wire wr_stat  = reg_wr && reg_addr == OFS_STAT;
    wire wr_tptr  = reg_wr && reg_addr == OFS_TPTR;
    wire wr_tlat  = reg_wr && reg_addr == OFS_TLAT;

    // ==========================================================
    // Sequencer
    always_comb begin
        state_next = state_reg;
        if (at_q4) begin
            case (state_reg)
                ST_EXEC: begin
                    if (is_tbl) begin
                        state_next = ST_TBL2;
                    end else if (skip_reg) begin
                        state_next = instr_two_word ? ST_NOP2 : ST_NOP1;
                    end else if (is_ulnk) begin
                        state_next = ST_NOP1;
                    end
                end
                ST_NOP2: state_next = ST_NOP1;
                ST_TBL2: state_next = ST_EXEC;
                ST_NOP1: state_next = ST_EXEC;
                default: state_next = ST_EXEC;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg  <= ST_EXEC;
            q_reg      <= Q1;
            ir_reg     <= OPC_NOP;
            instr_take <= 1'b0;
            cycle_nop  <= 1'b0;
            phase      <= Q1;
        end else begin
            state_reg  <= state_next;
            q_reg      <= 2'(q_reg + 2'h1);
            phase      <= 2'(q_reg + 2'h1);
            instr_take <= load_ir && instr_valid;
            // Skipped instruction is never loaded, so a nop runs in its place
            if (load_ir) begin
                ir_reg <= instr_valid ? instr_word : OPC_NOP;
            end
            if (at_q4) begin
                cycle_nop <= state_next == ST_NOP1 || state_next == ST_NOP2;
            end
        end
    end

    // ==========================================================
    // Data path: file access, xor, skip
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            file_addr  <= 12'h000;
            file_rd    <= 1'b0;
            file_wr    <= 1'b0;
            file_wdata <= 8'h00;
            skip_reg   <= 1'b0;
            ret_pop    <= 1'b0;
            ext_pass   <= 1'b0;
        end else begin
            file_rd  <= ex && at_q1 && uses_f;
            file_wr  <= ex && at_q3 && is_xwf && dest_f;
            ret_pop  <= ex && at_q4 && is_ulnk;
            ext_pass <= ex && at_q1 && is_xoth;
            if (at_q1) begin
                file_addr <= f_addr;
            end
            if (at_q3) begin
                file_wdata <= x_res;
                skip_reg   <= ex && is_tst && file_rdata == 8'h00;
            end
        end
    end

    // Instruction writes win over a register port write in the same cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            w_reg      <= RST_W;
            n_reg      <= 1'b0;
            z_reg      <= 1'b0;
            bsr_reg    <= RST_BANK;
            ext_en_reg <= RST_EXT;
        end else begin
            if (w_we_x) begin
                w_reg <= x_res;
            end else if (wr_w) begin
                w_reg <= reg_wdata[7:0];
            end
            // Only the xors and a STAT register write touch the flags; a table write never does
            if (flg_we) begin
                n_reg <= x_res[7];
                z_reg <= x_res == 8'h00;
            end else if (wr_stat) begin
                n_reg <= reg_wdata[STAT_N_BIT];
                z_reg <= reg_wdata[STAT_Z_BIT];
            end
            if (wr_bank) begin
                bsr_reg <= reg_wdata[3:0];
            end
            if (wr_ctrl) begin
                ext_en_reg <= reg_wdata[CTRL_EXT_BIT];
            end
        end
    end

    // ==========================================================
    // Table write and file select pointers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tptr_reg       <= RST_TPTR;
            tlat_reg       <= RST_LATCH;
            hold_latch_reg <= RST_LATCH;
            for (int i = 0; i < PTR_N; i++) begin
                ptr_reg[i] <= RST_PTR;
            end
        end else begin
            if (state_reg == ST_TBL2 && at_q2) begin
                hold_latch_reg <= tlat_reg;
            end
            if (pre_inc) begin
                tptr_reg <= tptr_step(tptr_reg, 1'b0);
            end else if (post_mv) begin
                tptr_reg <= tptr_step(tptr_reg, tw_mode == TW_POST_DEC);
            end else if (wr_tptr) begin
                tptr_reg <= reg_wdata[TPTR_W-1:0];
            end
            if (wr_tlat) begin
                tlat_reg <= reg_wdata[7:0];
            end
            for (int i = 0; i < PTR_N; i++) begin
                if (ptr_we && ptr_idx == 2'(i)) begin
                    ptr_reg[i] <= ptr_new;
                end else if (reg_wr && reg_addr == 8'(OFS_PTR0 + 8'(i) * PTR_STRIDE)) begin
                    ptr_reg[i] <= reg_wdata[PTR_W-1:0];
                end
            end
        end
    end

    // Low three pointer bits pick the holding byte; bit 0 is the byte in the word
    twxse_hold_mem u_hold (
        .clock   (clock),
        .rst_b   (rst_b),
        .wr_en   (hold_we),
        .wr_idx  (tptr_reg[HOLD_AW-1:0]),
        .wr_data (hold_latch_reg),
        .rd_idx  (hold_rd_idx),
        .rd_data (hold_rd_data)
    );

    // ==========================================================
    // Register port read
    always_comb begin
        case (reg_addr)
            OFS_CTRL: rd_mux = {31'h0, ext_en_reg};
            OFS_BANK: rd_mux = {28'h0, bsr_reg};
            OFS_WORKING_REGISTER: rd_mux = {24'h0, w_reg};
            OFS_STAT: rd_mux = {30'h0, n_reg, z_reg};
            OFS_TPTR: rd_mux = {11'h0, tptr_reg};
            OFS_TLAT: rd_mux = {24'h0, tlat_reg};
            8'h18:    rd_mux = {20'h0, ptr_reg[0]};
            8'h1C:    rd_mux = {20'h0, ptr_reg[1]};
            8'h20:    rd_mux = {20'h0, ptr_reg[2]};
            default:  rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_tbl_two_cycles;
        (ex && at_q4 && is_tbl) |=> (state_reg == ST_TBL2)[*4] ##1 ex;
    endproperty
    a_tbl_two_cycles: assert property (p_tbl_two_cycles) else $error("table write length");

    property p_tbl_hold;
        (state_reg == ST_TBL2 && at_q2 && !wr_tlat) |-> ##2 (hold_we && hold_latch_reg == $past(tlat_reg, 2));
    endproperty
    a_tbl_hold: assert property (p_tbl_hold) else $error("holding data wrong");

    property p_tptr_post;
        (hold_we && tw_mode == TW_POST_DEC) |=> tptr_reg == 21'($past(tptr_reg) - 21'h1);
    endproperty
    a_tptr_post: assert property (p_tptr_post) else $error("post decrement wrong");

    property p_tbl_flags;
        (state_reg == ST_TBL2 && !wr_stat) |=> $stable({n_reg, z_reg});
    endproperty
    a_tbl_flags: assert property (p_tbl_flags) else $error("flags changed");

    property p_skip;
        (ex && at_q3 && is_tst && file_rdata == 8'h00) |-> ##2 cycle_nop[*4];
    endproperty
    a_skip: assert property (p_skip) else $error("skip missing");

    property p_no_skip;
        (ex && at_q3 && is_tst && file_rdata != 8'h00) |-> ##2 (!cycle_nop)[*4];
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("spurious skip");

    property p_skip_two;
        (ex && at_q4 && skip_reg && instr_two_word) |=> cycle_nop[*8] ##1 !cycle_nop;
    endproperty
    a_skip_two: assert property (p_skip_two) else $error("two word skip length");

    property p_bank;
        (ex && at_q1 && ir_reg[8]) |=> file_addr == $past({bsr_reg, ir_reg[7:0]});
    endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong");

    property p_indexed;
        (ex && at_q1 && !ir_reg[8] && ext_en_reg && ir_reg[7:0] <= LIT_OFFSET_MAX)
        |=> file_addr == 12'($past(ptr_reg[2]) + {4'h0, $past(ir_reg[7:0])});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_xor_lit;
        (ex && at_q3 && is_xlw) |=> w_reg == ($past(w_reg) ^ $past(ir_reg[7:0]));
    endproperty
    a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");

    property p_xor_file;
        (ex && at_q3 && is_xwf && dest_f && !wr_w)
        |=> file_wr && file_wdata == ($past(w_reg) ^ $past(file_rdata)) && $stable(w_reg);
    endproperty
    a_xor_file: assert property (p_xor_file) else $error("xor file wrong");

    property p_xor_flags;
        flg_we |=> z_reg == ($past(x_res) == 8'h00) && n_reg == $past(x_res[7]);
    endproperty
    a_xor_flags: assert property (p_xor_flags) else $error("xor flags wrong");

    property p_ext_off;
        (!ext_en_reg && at_q1) |=> !ext_pass ##3 !ret_pop;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("extended op while disabled");

    property p_ret;
        (ex && at_q4 && is_ulnk) |=> ret_pop ##1 (!ret_pop && cycle_nop)[*3];
    endproperty
    a_ret: assert property (p_ret) else $error("return missing");

    c_skip:     cover property (ex && at_q3 && is_tst && file_rdata == 8'h00);
    c_skip_two: cover property (ex && at_q4 && skip_reg && instr_two_word);
    c_tbl:      cover property (hold_we && tw_mode == TW_PRE_INC);
    c_ret:      cover property (ret_pop);
endmodule

/* twxse_data_mem.sv */
// Data memory model facing the execution block's file port
`timescale 1ns/10ps
module twxse_data_mem (
    // Clock
    input  wire logic        clock,
    // File port
    input  wire logic [11:0] file_addr,
    input  wire logic        file_rd,
    input  wire logic        file_wr,
    input  wire logic [7:0]  file_wdata,
    output logic      [7:0]  file_rdata
);
    logic [7:0] mem [4096];
    initial file_rdata = 8'hA5;
    // ==========================================================
    // Access
    // Data toggles outside a read, so a stale byte never passes
    always @(posedge clock) begin
        if (file_wr) begin
            mem[file_addr] <= file_wdata;
        end
        file_rdata <= file_rd ? mem[file_addr] : ~file_rdata;
    end
endmodule

/* tb.sv */
// Self-checking bench for the table write, xor and skip execution block
`timescale 1ns/10ps
module tb
    import twxse_pkg::*;
;
    logic        clock = 1'b0, rst_b = 1'b0, instr_valid = 1'b0, instr_two_word = 1'b0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, instr_take, file_rd, file_wr;
    logic        cycle_nop, ret_pop, ext_pass;
    logic [1:0]  phase;
    logic [2:0]  hold_rd_idx = 3'h0;
    logic [7:0]  reg_addr = 8'h00, file_rdata, file_wdata, hold_rd_data;
    logic [11:0] file_addr;
    logic [15:0] instr_word = 16'h0000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    int          n_mismatch = 0, total_checks = 0, nn, np, nt, ne;
    always #25 clock = ~clock;
    twxse_exec u_twxse_exec (.clock(clock), .rst_b(rst_b), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_two_word(instr_two_word), .instr_take(instr_take),
        .file_rdata(file_rdata), .file_addr(file_addr), .file_rd(file_rd),
        .file_wr(file_wr), .file_wdata(file_wdata), .hold_rd_idx(hold_rd_idx),
        .hold_rd_data(hold_rd_data), .phase(phase), .cycle_nop(cycle_nop),
        .ret_pop(ret_pop), .ext_pass(ext_pass), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    twxse_data_mem u_mem (.clock(clock), .file_addr(file_addr), .file_rd(file_rd),
        .file_wr(file_wr), .file_wdata(file_wdata), .file_rdata(file_rdata));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        chk(reg_rdata, exp);
    endtask
    // Loads one word at a Q4 edge, then counts sixteen cycles of activity
    task automatic ex(input logic [15:0] w, input logic tw);
        nn = 0;
        np = 0;
        nt = 0;
        ne = 0;
        instr_two_word <= tw;
        do @(posedge clock); while (phase !== Q3);
        instr_word <= w;
        instr_valid <= 1'b1;
        @(posedge clock);
        instr_word <= OPC_NOP;
        repeat (16) begin
            @(posedge clock);
            if (cycle_nop === 1'b1) nn++;
            if (ret_pop === 1'b1) np++;
            if (instr_take === 1'b1) nt++;
            if (ext_pass === 1'b1) ne++;
        end
    endtask
    task automatic stop_test;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_xor_lit;
        wr(OFS_WORKING_REGISTER, 32'hB5);
        ex(16'h0AAF, 1'b0);
        rd(OFS_WORKING_REGISTER, 32'h1A);
        rd(OFS_STAT, 32'h0);
        ex(16'h0A1A, 1'b0);
        rd(OFS_STAT, 32'h1);
        ex(16'h0A80, 1'b0);
        rd(OFS_STAT, 32'h2);
    endtask
    task automatic t_xor_file;
        wr(OFS_WORKING_REGISTER, 32'hB5);
        u_mem.mem[12'h025] = 8'hAF;
        ex(16'h1A25, 1'b0);
        chk(32'(u_mem.mem[12'h025]), 32'h1A);
        rd(OFS_WORKING_REGISTER, 32'hB5);
        wr(OFS_BANK, 32'h2);
        u_mem.mem[12'h210] = 8'h5A;
        ex(16'h1910, 1'b0);
        rd(OFS_WORKING_REGISTER, 32'hEF);
        u_mem.mem[12'hF65] = 8'h0F;
        ex(16'h1A65, 1'b0);
        chk(32'(u_mem.mem[12'hF65]), 32'hE0);
        rd(OFS_STAT, 32'h2);
    endtask
    task automatic t_table_write_op;
        logic [20:0] p;
        for (int m = 0; m < 4; m++) begin
            p = (m == 2) ? 21'h00A355 : (m == 0) ? 21'h00A356 : 21'h00A357;
            wr(OFS_TPTR, 32'h00A356);
            wr(OFS_TLAT, 32'h50 + m);
            ex({OPC_TBL_WRITE, 2'(m)}, 1'b0);
            chk(32'(nt), 32'h3);
            rd(OFS_TPTR, 32'(p));
            rd(OFS_STAT, 32'h2);
            hold_rd_idx <= (m == 3) ? 3'h7 : 3'h6;
            repeat (2) @(posedge clock);
            chk(32'(hold_rd_data), 32'h50 + m);
        end
    endtask
    task automatic t_skip;
        u_mem.mem[12'h030] = 8'h00;
        u_mem.mem[12'h031] = 8'h01;
        ex(16'h6631, 1'b1);
        chk(32'(nn + 4 * nt), 32'h10);
        ex(16'h6630, 1'b0);
        chk(32'(nn + 4 * nt), 32'h10);
        chk(32'(nt), 32'h3);
        ex(16'h6630, 1'b1);
        chk(32'(nn), 32'h8);
        chk(32'(nt), 32'h2);
    endtask
    task automatic t_ext;
        wr(8'h20, 32'h3FF);
        ex(16'hE8A3, 1'b0);
        rd(8'h20, 32'h3FF);
        ex(OPC_CALL_W, 1'b0);
        chk(32'(ne), 32'h0);
        wr(OFS_CTRL, 32'h1);
        ex(OPC_CALL_W, 1'b0);
        chk(32'(ne), 32'h1);
        ex(16'hE8A3, 1'b0);
        rd(8'h20, 32'h422);
        ex(16'hE8C5, 1'b0);
        chk(32'(np * 16 + nn), 32'h14);
        ex(16'hE9C7, 1'b0);
        rd(8'h20, 32'h420);
        wr(OFS_WORKING_REGISTER, 32'hF0);
        u_mem.mem[12'h425] = 8'h0F;
        ex(16'h1A05, 1'b0);
        chk(32'(u_mem.mem[12'h425]), 32'hFF);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        rd(OFS_WORKING_REGISTER, 32'h0);
        rd(OFS_TPTR, 32'h0);
        rd(OFS_CTRL, 32'h0);
        rd(8'hFC, 32'h0);
        t_xor_lit;
        t_xor_file;
        t_table_write_op;
        t_skip;
        t_ext;
        stop_test;
    end
    // Run needs about five hundred cycles; allow ten thousand
    initial begin
        #500000;
        n_mismatch++;
        stop_test;
    end
endmodule
